// *** hdl/bsar_top.v ***
`timescale 1ns/10ps
`include "bsar_map.vh"
// How it works
// R1: Tester loads idle values into converter cells when converter is unused.
// R2: Latch is precharged while the precharge cell is low; high lets it resolve.
// R3: Three-bit minus-input pick selects the comparator negative input.
// R4: Probe enable routes amplifier output to the channel four pin.
// R5: Tester may hold speedup high two clock periods after amp power-on.
// R6: Supply-as-reference cell selects supply as converter reference.
// R7: Tester selects exactly one path onto the negative input.
// R8: Tester should leave the differential amplifier unused during scan.
// R9: Tester checks lower limit gives low result, upper limit gives high.
// R10: Tester sets measured pin as input with pull-up disabled.
// R11: Enabling the converter starts a dummy conversion of ten comparisons.
// R12: Tester waits 200 ns after enable or discards the first result.
// R13: Reference code stays at midpoint while sampling.
// R14: Tester preloads first vector, then uses external test for the rest.
// R15: Channel three check follows sample, freeze, limit, precharge, restore.
// R16: Result is read in the scan following the precharge pulse.
// R17: Test clock must be fast enough for freeze held over five vectors.
module bsar_top (
    input  wire                    i_ref_clk,
    input  wire                    i_sys_rst,
    input  wire                    i_tck,
    input  wire                    i_update,
    input  wire [`BSAR_CH_W-1:0]   i_channel_pick_bits,
    input  wire [`BSAR_NEG_W-1:0]  i_minus_input_pick,
    input  wire                    i_amp_passgate_on,
    input  wire                    i_latch_charge_n,
    input  wire                    i_switchcap_probe_en,
    input  wire                    i_amp_speedup,
    input  wire                    i_supply_as_reference,
    input  wire                    i_diffamp_power_on,
    input  wire                    i_converter_power_on,
    input  wire                    i_hold,
    input  wire [`BSAR_DAC_W-1:0]  i_dac_code,
    input  wire                    i_comp_raw,
    output reg  [`BSAR_CH_W-1:0]   o_channel_pick_bits,
    output reg  [`BSAR_NEG_W-1:0]  o_minus_input_pick,
    output reg                     o_amp_passgate_on,
    output reg                     o_latch_precharge,
    output reg                     o_probe_to_ch4_pin,
    output reg                     o_amp_speedup,
    output reg                     o_vref_is_supply,
    output reg                     o_diffamp_power_on,
    output reg                     o_hold,
    output reg  [`BSAR_DAC_W-1:0]  o_dac_code,
    output reg                     o_comp_result,
    output reg                     o_dummy_busy,
    output reg                     o_converter_ready,
    output reg                     o_tck_rise
);
    wire tck_s;
    wire upd_s;
    wire en_s;
    wire comp_s;
    reg  tck_prev_q;
    reg  upd_prev_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [3:0] cmp_cnt_q;
    reg  [3:0] cmp_cnt_d;
    reg  [3:0] step_q;
    reg  [3:0] step_d;
    reg  [`BSAR_CNT_W-1:0] settle_q;
    reg  [`BSAR_CNT_W-1:0] settle_d;
    wire [`BSAR_CELL_W-1:0] cells_raw;
    wire [`BSAR_CELL_W-1:0] cells_s;
    wire [`BSAR_CH_W-1:0]   cell_ch;
    wire [`BSAR_NEG_W-1:0]  cell_neg;
    wire                    cell_pass;
    wire                    cell_lc_n;
    wire                    cell_probe;
    wire                    cell_st;
    wire                    cell_vcc;
    wire                    cell_amp;
    wire                    cell_hold;
    wire [`BSAR_DAC_W-1:0]  cell_dac;
    wire                    cell_load;
    wire                    latch_charge_n_d;

    bsar_sync2 u_s_tck (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
                        .i_async(i_tck), .o_sync(tck_s));
    bsar_sync2 u_s_upd (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
                        .i_async(i_update), .o_sync(upd_s));
    bsar_sync2 u_s_en (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
                       .i_async(i_converter_power_on), .o_sync(en_s));
    bsar_sync2 u_s_cmp (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
                        .i_async(i_comp_raw), .o_sync(comp_s));

    // The cell word crosses on the same two-stage depth as the update strobe. It is
    // quiet for many clocks before the strobe rises, so skew between its bits never shows.
    bsar_sync2 #(.WIDTH(`BSAR_CELL_W)) u_s_cells (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
                                                  .i_async(cells_raw), .o_sync(cells_s));
    assign cells_raw = {i_channel_pick_bits, i_minus_input_pick, i_amp_passgate_on,
                        i_latch_charge_n, i_switchcap_probe_en, i_amp_speedup,
                        i_supply_as_reference, i_diffamp_power_on, i_hold, i_dac_code};
    assign {cell_ch, cell_neg, cell_pass, cell_lc_n, cell_probe, cell_st,
            cell_vcc, cell_amp, cell_hold, cell_dac} = cells_s;

    // A rising edge of the synchronised update strobe applies the whole cell word.
    assign cell_load = upd_s & ~upd_prev_q;
    // Precharge value in force after this edge, so the result is cleared in step with it.
    assign latch_charge_n_d = cell_load ? ~cell_lc_n : o_latch_precharge; // R2

    // Enabling the converter runs ten dummy comparisons, then settles.
    always @* begin
        state_d = state_q;
        cmp_cnt_d = cmp_cnt_q;
        step_d = step_q;
        settle_d = settle_q;
        case (state_q)
            `BSAR_ST_IDLE: begin
                if (en_s) begin
                    state_d = `BSAR_ST_DUMMY; // R11
                    cmp_cnt_d = 4'h0;
                    step_d = 4'h0;
                    settle_d = {`BSAR_CNT_W{1'b0}};
                end
            end
            `BSAR_ST_DUMMY: begin
                if (!en_s) begin
                    state_d = `BSAR_ST_IDLE;
                end else begin
                    // The settle count saturates, so ready stays up while enabled.
                    if (settle_q != `BSAR_SETTLE_CYC) begin
                        settle_d = settle_q + 8'h01;
                    end
                    // Each comparison lasts a fixed number of clocks, paced by the step count.
                    if (step_q == `BSAR_CMP_STEP_CYC - 4'h1) begin
                        step_d = 4'h0;
                        cmp_cnt_d = cmp_cnt_q + 4'h1;
                        if (cmp_cnt_q == `BSAR_DUMMY_CMPS - 4'h1) begin
                            state_d = `BSAR_ST_READY; // R11
                        end
                    end else begin
                        step_d = step_q + 4'h1;
                    end
                end
            end
            `BSAR_ST_READY: begin
                if (!en_s) begin
                    state_d = `BSAR_ST_IDLE;
                end else if (settle_q != `BSAR_SETTLE_CYC) begin
                    settle_d = settle_q + 8'h01;
                end
            end
            default: begin
                state_d = `BSAR_ST_IDLE;
            end
        endcase
    end

    // Each rising test clock edge seen after synchronisation gives a one-clock pulse.
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            tck_prev_q <= 1'b0;
            o_tck_rise <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
            o_tck_rise <= tck_s & ~tck_prev_q;
        end
    end

    // Cell outputs load together on the update edge and hold the idle values through reset.
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            upd_prev_q <= 1'b0;
            state_q <= `BSAR_ST_IDLE;
            cmp_cnt_q <= 4'h0;
            step_q <= 4'h0;
            settle_q <= {`BSAR_CNT_W{1'b0}};
            o_channel_pick_bits <= `BSAR_CH_IDLE;
            o_minus_input_pick <= `BSAR_NEG_IDLE;
            o_amp_passgate_on <= `BSAR_PASS_IDLE;
            o_latch_precharge <= `BSAR_LATCH_CHARGE_N_IDLE;
            o_probe_to_ch4_pin <= 1'b0;
            o_amp_speedup <= 1'b0;
            o_vref_is_supply <= 1'b0;
            o_diffamp_power_on <= 1'b0;
            o_hold <= `BSAR_HOLD_IDLE;
            o_dac_code <= `BSAR_DAC_MID;
            o_dummy_busy <= 1'b0;
            o_converter_ready <= 1'b0;
        end else begin
            upd_prev_q <= upd_s;
            state_q <= state_d;
            cmp_cnt_q <= cmp_cnt_d;
            step_q <= step_d;
            settle_q <= settle_d;
            // Status flags follow the next state, so busy moves on the same edge as the state; ready also waits for the settle count.
            o_dummy_busy <= (state_d == `BSAR_ST_DUMMY);
            o_converter_ready <= (state_d == `BSAR_ST_READY) &&
                                 (settle_d == `BSAR_SETTLE_CYC);
            if (cell_load) begin
                o_channel_pick_bits <= cell_ch;
                o_minus_input_pick <= cell_neg; // R3
                o_amp_passgate_on <= cell_pass;
                o_latch_precharge <= ~cell_lc_n; // R2
                o_probe_to_ch4_pin <= cell_probe; // R4
                o_amp_speedup <= cell_st;
                o_vref_is_supply <= cell_vcc; // R6
                o_diffamp_power_on <= cell_amp;
                o_hold <= cell_hold;
                o_dac_code <= cell_dac;
            end
        end
    end

    // The result is cleared by the precharge value being applied on this edge, so a
    // result never stands beside a freshly raised precharge.
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_comp_result <= 1'b0;
        end else if (latch_charge_n_d) begin
            o_comp_result <= 1'b0; // R2
        end else begin
            o_comp_result <= comp_s;
        end
    end
endmodule

// *** pkg/bsar_map.vh ***
`ifndef BSAR_MAP_VH
`define BSAR_MAP_VH
`define BSAR_CH_W          8
`define BSAR_NEG_W         3
`define BSAR_DAC_W         10
`define BSAR_CHAIN_LEN     8'd32
`define BSAR_CNT_W         8
`define BSAR_CH_IDLE       8'h01
`define BSAR_NEG_IDLE      3'h0
`define BSAR_DAC_MID       10'h200
`define BSAR_DUMMY_CMPS    4'ha
`define BSAR_CMP_STEP_CYC  4'h2
`define BSAR_ENABLE_NS     200
`define BSAR_CLK_NS        8
`define BSAR_SETTLE_CYC    8'h19
`define BSAR_CELL_W        28
`define BSAR_PASS_IDLE     1'b1
`define BSAR_HOLD_IDLE     1'b1
`define BSAR_LATCH_CHARGE_N_IDLE    1'b0
`define BSAR_ST_IDLE       2'h0
`define BSAR_ST_DUMMY      2'h1
`define BSAR_ST_READY      2'h2
`endif

// *** hdl/bsar_sync2.v ***
`timescale 1ns/10ps
// Two-stage synchroniser for levels from outside the clock domain.
module bsar_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             i_ref_clk,
    input  wire             i_sys_rst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule

// *** test/bsar_props.sv ***
`timescale 1ns/10ps
// Watches the minus pick, precharge, probe and reference cell outputs of the scan block.
module bsar_props (
    input wire       i_ref_clk,
    input wire       i_sys_rst,
    input wire       i_update,
    input wire       i_latch_charge_n,
    input wire       i_switchcap_probe_en,
    input wire       i_supply_as_reference,
    input wire       i_converter_power_on,
    input wire [2:0] i_minus_input_pick,
    input wire [2:0] o_minus_input_pick,
    input wire       o_latch_precharge,
    input wire       o_probe_to_ch4_pin,
    input wire       o_vref_is_supply,
    input wire       o_comp_result,
    input wire       o_dummy_busy
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    AST_LATCH_CHARGE_N_LOW: assert property (o_latch_precharge |-> !o_comp_result)
        else $error("result not low while precharging");
    AST_LATCH_CHARGE_N_LOAD: assert property ($rose(i_update) |-> ##6
        o_latch_precharge == !$past(i_latch_charge_n, 6)) else $error("precharge not loaded");
    AST_MINUS_PICK: assert property ($rose(i_update) |-> ##6
        o_minus_input_pick == $past(i_minus_input_pick, 6)) else $error("minus pick not loaded");
    AST_PROBE: assert property ($rose(i_update) |-> ##6
        o_probe_to_ch4_pin == $past(i_switchcap_probe_en, 6)) else $error("probe not loaded");
    AST_VREF: assert property ($rose(i_update) |-> ##6
        o_vref_is_supply == $past(i_supply_as_reference, 6)) else $error("vref not loaded");
    AST_DUMMY_START: assert property ($rose(i_converter_power_on) |-> ##[2:5] o_dummy_busy)
        else $error("dummy conversion did not start");
    AST_DUMMY_LEN: assert property ($rose(o_dummy_busy) |-> ##18 o_dummy_busy
        ##[1:4] !o_dummy_busy) else $error("dummy conversion length wrong");
    cover property ($rose(i_update));
    cover property ($rose(o_dummy_busy));
    cover property ($fell(o_latch_precharge) ##[1:20] o_comp_result);
endmodule
bind bsar_top bsar_props u_props (.i_ref_clk, .i_sys_rst, .i_update, .i_latch_charge_n,
    .i_switchcap_probe_en, .i_supply_as_reference, .i_converter_power_on, .i_minus_input_pick,
    .o_minus_input_pick, .o_latch_precharge, .o_probe_to_ch4_pin, .o_vref_is_supply,
    .o_comp_result, .o_dummy_busy);

// *** test/bsar_tester.sv ***
`timescale 1ns/10ps
// Scan tester: shifts a frame on the test clock, then strobes update.
module bsar_tester (
    input  wire        i_ref_clk,
    output logic       o_tck,
    output logic       o_update,
    output logic       o_pass,
    output logic       o_lc_n,
    output logic       o_probe,
    output logic       o_st,
    output logic       o_vcc,
    output logic       o_amp,
    output logic       o_hold,
    output logic [7:0] o_ch,
    output logic [2:0] o_neg,
    output logic [9:0] o_dac
);
    initial begin
        {o_tck, o_update, o_probe, o_st, o_vcc, o_amp, o_neg} = 0;
        {o_pass, o_lc_n, o_hold, o_ch, o_dac} = {3'h7, 8'h01, 10'h200};
    end
    task vec(input logic [7:0] c, input logic [9:0] d, input logic h, l,
             input logic [2:0] n, input logic p, v);
        @(posedge i_ref_clk) #1;
        {o_ch, o_dac, o_hold, o_lc_n, o_neg, o_probe, o_vcc} = {c, d, h, l, n, p, v};
        repeat (4) begin
            #32 o_tck = 1;
            #32 o_tck = 0;
        end
        @(posedge i_ref_clk) #1 o_update = 1;
        repeat (3) @(posedge i_ref_clk);
        #1 o_update = 0;
        repeat (10) @(posedge i_ref_clk);
        #1;
    endtask
endmodule

// *** test/bsar_top_tb_top.sv ***
`timescale 1ns/10ps
module bsar_top_tb_top;
    logic clk = 0, rst = 1, en = 0, lat = 0, tck, upd, pass, lc_n, probe, st, vcc, amp, hold;
    logic [7:0] ch, o_ch;
    logic [2:0] neg, o_neg;
    logic [9:0] dac, o_dac, d, vin = 10'h130;
    logic o_pass, o_latch_charge_n, o_probe, o_st, o_vcc, o_amp, o_hold, o_comp, o_busy, o_rdy, o_tr;
    int fail_count = 0, n_compared = 0, nr = 0, ne = 0, i;
    logic [27:0] exp_q[$];
    always #4 clk = ~clk;
    always @(posedge clk) if (o_tr) nr <= nr + 1;
    // The comparator latch follows while precharged and holds once released.
    always @(posedge clk) if (o_latch_charge_n) lat <= (o_dac >= vin);
    bsar_tester u_t (.i_ref_clk(clk), .o_tck(tck), .o_update(upd), .o_pass(pass), .o_lc_n(lc_n),
        .o_probe(probe), .o_st(st), .o_vcc(vcc), .o_amp(amp), .o_hold(hold), .o_ch(ch),
        .o_neg(neg), .o_dac(dac));
    bsar_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_tck(tck), .i_update(upd),
        .i_channel_pick_bits(ch), .i_minus_input_pick(neg), .i_amp_passgate_on(pass),
        .i_latch_charge_n(lc_n), .i_switchcap_probe_en(probe), .i_amp_speedup(st),
        .i_supply_as_reference(vcc), .i_diffamp_power_on(amp), .i_converter_power_on(en),
        .i_hold(hold), .i_dac_code(dac), .i_comp_raw(lat), .o_channel_pick_bits(o_ch),
        .o_minus_input_pick(o_neg), .o_amp_passgate_on(o_pass), .o_latch_precharge(o_latch_charge_n),
        .o_probe_to_ch4_pin(o_probe), .o_amp_speedup(o_st), .o_vref_is_supply(o_vcc),
        .o_diffamp_power_on(o_amp), .o_hold(o_hold), .o_dac_code(o_dac),
        .o_comp_result(o_comp), .o_dummy_busy(o_busy), .o_converter_ready(o_rdy),
        .o_tck_rise(o_tr));
    task chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task step(input logic [7:0] c, input logic [9:0] dd, input logic h, l,
              input logic [2:0] n, input logic p, v);
        exp_q.push_back({c, n, dd, h, !l, p, v, 3'h4});
        u_t.vec(c, dd, h, l, n, p, v);
        ne += 4;
        chk({o_ch, o_neg, o_dac, o_hold, o_latch_charge_n, o_probe, o_vcc, o_pass, o_st, o_amp},
            exp_q.pop_front());
        chk(nr, ne);
    endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        end_of_test;
    end
    initial begin
        i = $urandom(43029);
        repeat (6) @(posedge clk);
        #1 rst = 0;
        @(posedge clk) #1;
        chk({o_ch, o_neg, o_pass, o_hold, o_dac, o_latch_charge_n, o_probe, o_st, o_vcc, o_amp, o_comp,
             o_busy, o_rdy}, {8'h01, 3'h0, 1'b1, 1'b1, 10'h200, 8'h00});
        en = 1;
        repeat (10) @(posedge clk) #1;
        chk({o_busy, o_rdy}, 2'h2);
        repeat (25) @(posedge clk) #1;
        chk({o_busy, o_rdy}, 2'h1);
        for (i = 0; i < 11; i++) begin
            d = (i == 3 || i == 4) ? 10'h123 : (i == 8 || i == 9) ? 10'h143 : 10'h200;
            step(8'h08, d, !(i == 1 || i == 6), !(i == 4 || i == 9), 0, 0, 0);
            if (i == 5 || i == 10) chk(o_comp, ((i == 10) ? 10'h143 : 10'h123) >= vin);
            if (i == 4 || i == 9) chk(o_comp, 0);
        end
        repeat (4) step(8'h01, 10'h200, 1, 1, 3'($urandom), 1'($urandom), 1'($urandom));
        end_of_test;
    end
endmodule
